//--- pkg/monitor_pkg.sv
// Constants, states and carriers for the monitor command port.
// Assumes a single 200 MHz mclk; bit timing is counted in baud ticks.
package monitor_pkg;

  // Baud divisors: bus clock over these figures
  localparam int unsigned DIV_EXT_DEF = 256;
  localparam int unsigned DIV_INT_DEF = 335;
  localparam int unsigned DIV_W       = 9;

  // Bit-time counts
  localparam logic [3:0] GAP_BITS   = 4'h2;
  localparam logic [3:0] TX_BITS    = 4'hC;
  localparam logic [3:0] RX_LAST    = 4'h9;
  localparam logic [3:0] WAIT_BITS  = 4'hB;

  // Security
  localparam logic [3:0]  SEC_BYTES     = 4'h8;
  localparam logic [15:0] SEC_FLAG_ADDR = 16'h0080;
  localparam int unsigned SEC_FLAG_BIT  = 6;
  localparam logic [7:0]  SEC_FLAG_SET  = 8'h40;

  // Stacked frame, upward from the stack pointer
  localparam logic [15:0] FRM_IDX_HI = 16'h0001;
  localparam logic [15:0] FRM_CCR    = 16'h0002;
  localparam logic [15:0] FRM_ACC    = 16'h0003;
  localparam logic [15:0] FRM_IDX_LO = 16'h0004;
  localparam logic [15:0] FRM_PC_HI  = 16'h0005;
  localparam logic [15:0] FRM_PC_LO  = 16'h0006;

  typedef enum logic [3:0] {
    S_TRAP     = 4'h0,
    S_PUSH     = 4'h1,
    S_SEC_RX   = 4'h2,
    S_SEC_ECHO = 4'h3,
    S_BRK_TX   = 4'h4,
    S_CMD_RX   = 4'h5,
    S_ECHO     = 4'h6,
    S_OPD_RX   = 4'h7,
    S_WAIT     = 4'h8,
    S_MEM      = 4'h9,
    S_DATA_TX  = 4'hA,
    S_BRK_RESP = 4'hB,
    S_POP      = 4'hC,
    S_RETURN   = 4'hD,
    S_RUN      = 4'hE
  } state_t;

  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mem_req_t;

  typedef struct packed {
    logic software_trap_instr;
    logic push_index_high_instr;
    logic pop_index_high_instr;
    logic return_from_trap_instr;
  } cpu_seq_t;

endpackage : monitor_pkg

//--- verilog/monitor_debug_command_port.sv
// Monitor command interpreter on a single-wire half-duplex serial pin.
// Assumes an external pullup on the pin and a memory port answering
// mem_valid with a one-cycle mem_ready carrying read data.
// Contract
// - Echo every received byte to host
// - Wait eleven bits; break cancels command
// - Two-bit gap before echo and data
// - Read data follows last command echo
// - Indexed commands step consecutive addresses
// - Entry: software trap, then push index high
// - Resume: pop index high, then return
// - Stack query returns pointer plus one
// - Frame: XH, CCR, A, XL, PCH, PCL
// - After power-on, compare eight security bytes
// - Match unlocks flash until power-on reset
// - Mismatch: no flash reads, fetch resets; read commands are issued without checking unlock_q
// - Ready break only after eight bytes
// - RAM 0x80 bit 6 shows match
// - Retry by power-on reset or erase
// - Break: drive high two bits, echo
// - NRZ, same baud both directions
// - Baud is bus over 256 or 335
`timescale 1ns/1ps
module monitor_debug_command_port #(
  parameter int unsigned DIV_EXT    = monitor_pkg::DIV_EXT_DEF,
  parameter int unsigned DIV_INT    = monitor_pkg::DIV_INT_DEF,
  parameter logic [7:0]  OP_READ    = 8'h01,
  parameter logic [7:0]  OP_WRITE   = 8'h02,
  parameter logic [7:0]  OP_IFETCH  = 8'h03,
  parameter logic [7:0]  OP_ISTORE  = 8'h04,
  parameter logic [7:0]  OP_SPQUERY = 8'h05,
  parameter logic [7:0]  OP_RUN     = 8'h06
) (
  // Clock and resets
  input  wire logic                  mclk,
  input  wire logic                  reset,
  input  wire logic                  por,
  // Clock source
  input  wire logic                  int_osc_mode,
  // Monitor serial pin
  input  wire logic                  monitor_serial_pin_in,
  output logic                       monitor_serial_pin_out,
  output logic                       monitor_serial_pin_oe_n,
  // Security
  input  wire logic [63:0]           flash_code,
  input  wire logic                  flash_fetch,
  output logic                       flash_unlocked,
  output logic                       illegal_addr_reset,
  // CPU
  input  wire logic [15:0]           stack_ptr,
  output monitor_pkg::cpu_seq_t      cpu_seq,
  // Memory
  output logic                       mem_valid,
  output monitor_pkg::mem_req_t      mem_req,
  input  wire logic                  mem_ready,
  input  wire logic [7:0]            mem_rdata
);

  localparam int unsigned W = monitor_pkg::DIV_W;

  if (DIV_EXT < 4 || DIV_EXT > 511 || DIV_INT < 4 || DIV_INT > 511)
  begin : g_div_check
    $error("Baud divisor out of range 4..511");
  end

  monitor_pkg::state_t   state_q, state_d;
  monitor_pkg::mem_req_t mem_req_q, mem_req_d;
  monitor_pkg::cpu_seq_t cpu_seq_q, cpu_seq_d;
  logic [W-1:0]  div_q, div_d, rx_cnt_q, rx_cnt_d;
  logic [11:0]   tx_sh_q, tx_sh_d;
  logic [3:0]    tx_cnt_q, tx_cnt_d, rx_bit_q, rx_bit_d;
  logic [9:0]    rx_sh_q, rx_sh_d;
  logic          rx_act_q, rx_act_d, rx_arm_q, rx_arm_d;
  logic [3:0]    sec_cnt_q, sec_cnt_d, wait_q, wait_d;
  logic          sec_bad_q, sec_bad_d, sec_wr_q, sec_wr_d;
  logic          sec_done_q, sec_done_d, unlock_q, unlock_d;
  logic [7:0]    op_q, op_d, out_lo_q, out_lo_d;
  logic [23:0]   opnd_q, opnd_d;
  logic [1:0]    left_q, left_d;
  logic          more_q, more_d, mem_valid_q, mem_valid_d;
  logic [15:0]   ptr_q, ptr_d;
  logic          illegal_q, illegal_d;

  logic [W-1:0]  div_m1;
  logic          bit_tick, tx_done, rx_done, rx_ok, rx_brk;
  logic [9:0]    rx_frame;
  logic          tx_go;
  logic [11:0]   tx_frame;
  logic [15:0]   sp_plus;

  // Idle high gap, start, data LSB first, stop
  function automatic logic [11:0] byte_frame(input logic [7:0] b);
    byte_frame = {1'b1, b, 1'b0, 2'b11};
  endfunction : byte_frame

  // Two high bit times, then ten low bits
  localparam logic [11:0] BRK_FRAME = {10'h000, 2'b11};

  assign div_m1 = int_osc_mode ? W'(DIV_INT - 1) : W'(DIV_EXT - 1);

  always_comb
  begin
    state_d     = state_q;
    mem_req_d   = mem_req_q;
    cpu_seq_d   = '0;
    rx_cnt_d    = rx_cnt_q;
    rx_bit_d    = rx_bit_q;
    rx_sh_d     = rx_sh_q;
    rx_act_d    = rx_act_q;
    rx_arm_d    = rx_arm_q;
    sec_cnt_d   = sec_cnt_q;
    sec_bad_d   = sec_bad_q;
    sec_wr_d    = sec_wr_q;
    sec_done_d  = sec_done_q;
    unlock_d    = unlock_q;
    wait_d      = wait_q;
    op_d        = op_q;
    out_lo_d    = out_lo_q;
    opnd_d      = opnd_q;
    left_d      = left_q;
    more_d      = more_q;
    mem_valid_d = mem_valid_q;
    ptr_d       = ptr_q;
    tx_go       = 1'b0;
    tx_frame    = BRK_FRAME;
    illegal_d   = flash_fetch & ~unlock_q;
    sp_plus     = stack_ptr + monitor_pkg::FRM_IDX_HI;

    // Shared bit clock for transmit and the post-command wait
    bit_tick = (div_q == div_m1);
    div_d    = bit_tick ? '0 : div_q + W'(1);

    // Transmitter shifts one bit per tick, pin released after
    tx_sh_d  = tx_sh_q;
    tx_cnt_d = tx_cnt_q;
    tx_done  = 1'b0;
    if (tx_cnt_q != 4'h0 && bit_tick)
    begin
      tx_sh_d  = {1'b1, tx_sh_q[11:1]};
      tx_cnt_d = tx_cnt_q - 4'h1;
      tx_done  = (tx_cnt_q == 4'h1);
    end

    // Receiver: mid-bit sampling, same divisor as transmit
    rx_frame = {monitor_serial_pin_in, rx_sh_q[9:1]};
    rx_done  = 1'b0;
    if (tx_cnt_q != 4'h0)
    begin
      rx_act_d = 1'b0;
      rx_arm_d = 1'b0;
    end
    else if (!rx_act_q)
    begin
      if (monitor_serial_pin_in)
        rx_arm_d = 1'b1;
      else if (rx_arm_q)
      begin
        rx_act_d = 1'b1;
        rx_cnt_d = div_m1 >> 1;
        rx_bit_d = 4'h0;
      end
    end
    else if (rx_cnt_q == '0)
    begin
      rx_sh_d  = rx_frame;
      rx_cnt_d = div_m1;
      rx_bit_d = rx_bit_q + 4'h1;
      if (rx_bit_q == monitor_pkg::RX_LAST)
      begin
        rx_done  = 1'b1;
        rx_act_d = 1'b0;
        rx_arm_d = 1'b0;
      end
    end
    else
      rx_cnt_d = rx_cnt_q - W'(1);
    rx_brk = rx_done && (rx_frame == 10'h000);
    rx_ok  = rx_done && rx_frame[9] && !rx_frame[0];

    case (state_q)
      monitor_pkg::S_TRAP:
      begin
        cpu_seq_d.software_trap_instr = 1'b1;
        state_d = monitor_pkg::S_PUSH;
      end
      monitor_pkg::S_PUSH:
      begin
        cpu_seq_d.push_index_high_instr = 1'b1;
        if (sec_done_q)
        begin
          tx_go   = 1'b1;
          state_d = monitor_pkg::S_BRK_TX;
        end
        else
          state_d = monitor_pkg::S_SEC_RX;
      end
      monitor_pkg::S_SEC_RX:
        if (rx_ok)
        begin
          if (rx_frame[8:1] != flash_code[sec_cnt_q[2:0]*8 +: 8])
            sec_bad_d = 1'b1;
          tx_go    = 1'b1;
          tx_frame = byte_frame(rx_frame[8:1]);
          state_d  = monitor_pkg::S_SEC_ECHO;
        end
      monitor_pkg::S_SEC_ECHO:
        if (tx_done)
        begin
          sec_cnt_d = sec_cnt_q + 4'h1;
          if (sec_cnt_q == monitor_pkg::SEC_BYTES - 4'h1)
          begin
            sec_done_d  = 1'b1;
            unlock_d    = ~sec_bad_q;
            sec_wr_d    = 1'b1;
            mem_valid_d = 1'b1;
            mem_req_d   = '{we: 1'b1, addr: monitor_pkg::SEC_FLAG_ADDR,
                            wdata: sec_bad_q ? 8'h00 : monitor_pkg::SEC_FLAG_SET};
            state_d     = monitor_pkg::S_MEM;
          end
          else
            state_d = monitor_pkg::S_SEC_RX;
        end
      monitor_pkg::S_BRK_TX, monitor_pkg::S_BRK_RESP:
        if (tx_done)
          state_d = monitor_pkg::S_CMD_RX;
      monitor_pkg::S_CMD_RX, monitor_pkg::S_OPD_RX:
        if (rx_brk)
        begin
          tx_go   = 1'b1;
          state_d = monitor_pkg::S_BRK_RESP;
        end
        else if (rx_ok)
        begin
          tx_go    = 1'b1;
          tx_frame = byte_frame(rx_frame[8:1]);
          state_d  = monitor_pkg::S_ECHO;
          if (state_q == monitor_pkg::S_CMD_RX)
          begin
            op_d = rx_frame[8:1];
            if (rx_frame[8:1] == OP_WRITE)
              left_d = 2'h3;
            else if (rx_frame[8:1] == OP_READ)
              left_d = 2'h2;
            else if (rx_frame[8:1] == OP_ISTORE)
              left_d = 2'h1;
            else
              left_d = 2'h0;
          end
          else
          begin
            opnd_d = {opnd_q[15:0], rx_frame[8:1]};
            left_d = left_q - 2'h1;
          end
        end
      monitor_pkg::S_ECHO:
        if (tx_done)
        begin
          if (left_q != 2'h0)
            state_d = monitor_pkg::S_OPD_RX;
          else
          begin
            div_d   = '0;
            wait_d  = 4'h0;
            state_d = monitor_pkg::S_WAIT;
          end
        end
      monitor_pkg::S_WAIT:
        if (rx_brk)
        begin
          tx_go   = 1'b1;
          state_d = monitor_pkg::S_BRK_RESP;
        end
        else if (bit_tick)
        begin
          wait_d = wait_q + 4'h1;
          if (wait_q == monitor_pkg::WAIT_BITS - 4'h1)
          begin
            state_d     = monitor_pkg::S_MEM;
            mem_valid_d = 1'b1;
            if (op_q == OP_READ)
              mem_req_d = '{we: 1'b0, addr: opnd_q[15:0], wdata: 8'h00};
            else if (op_q == OP_WRITE)
              mem_req_d = '{we: 1'b1, addr: opnd_q[23:8], wdata: opnd_q[7:0]};
            else if (op_q == OP_IFETCH)
              mem_req_d = '{we: 1'b0, addr: ptr_q, wdata: 8'h00};
            else if (op_q == OP_ISTORE)
              mem_req_d = '{we: 1'b1, addr: ptr_q, wdata: opnd_q[7:0]};
            else
            begin
              mem_valid_d = 1'b0;
              if (op_q == OP_SPQUERY)
              begin
                tx_go    = 1'b1;
                tx_frame = byte_frame(sp_plus[15:8]);
                out_lo_d = sp_plus[7:0];
                more_d   = 1'b1;
                state_d  = monitor_pkg::S_DATA_TX;
              end
              else if (op_q == OP_RUN)
                state_d = monitor_pkg::S_POP;
              else
                state_d = monitor_pkg::S_CMD_RX;
            end
          end
        end
      monitor_pkg::S_MEM:
        if (mem_ready)
        begin
          mem_valid_d = 1'b0;
          if (sec_wr_q)
          begin
            sec_wr_d = 1'b0;
            tx_go    = 1'b1;
            state_d  = monitor_pkg::S_BRK_TX;
          end
          else
          begin
            ptr_d = mem_req_q.addr + 16'h0001;
            if (!mem_req_q.we)
            begin
              tx_go    = 1'b1;
              tx_frame = byte_frame(mem_rdata);
              more_d   = 1'b0;
              state_d  = monitor_pkg::S_DATA_TX;
            end
            else
              state_d = monitor_pkg::S_CMD_RX;
          end
        end
      monitor_pkg::S_DATA_TX:
        if (tx_done)
        begin
          if (more_q)
          begin
            tx_go    = 1'b1;
            tx_frame = byte_frame(out_lo_q);
            more_d   = 1'b0;
          end
          else
            state_d = monitor_pkg::S_CMD_RX;
        end
      monitor_pkg::S_POP:
      begin
        cpu_seq_d.pop_index_high_instr = 1'b1;
        state_d = monitor_pkg::S_RETURN;
      end
      monitor_pkg::S_RETURN:
      begin
        cpu_seq_d.return_from_trap_instr = 1'b1;
        state_d = monitor_pkg::S_RUN;
      end
      default:
        state_d = state_q;
    endcase

    // New frame restarts the bit clock so the gap is exact
    if (tx_go)
    begin
      tx_sh_d  = tx_frame;
      tx_cnt_d = monitor_pkg::TX_BITS;
      div_d    = '0;
    end
  end

  // Unlock survives every reset but power-on
  always_ff @(posedge mclk)
  begin
    if (por)
    begin
      sec_done_q <= 1'b0;
      unlock_q   <= 1'b0;
    end
    else
    begin
      sec_done_q <= sec_done_d;
      unlock_q   <= unlock_d;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset || por)
    begin
      state_q     <= monitor_pkg::S_TRAP;
      mem_req_q   <= '0;
      cpu_seq_q   <= '0;
      div_q       <= '0;
      tx_sh_q     <= 12'hFFF;
      tx_cnt_q    <= 4'h0;
      rx_cnt_q    <= '0;
      rx_bit_q    <= 4'h0;
      rx_sh_q     <= 10'h000;
      rx_act_q    <= 1'b0;
      rx_arm_q    <= 1'b0;
      sec_cnt_q   <= 4'h0;
      sec_bad_q   <= 1'b0;
      sec_wr_q    <= 1'b0;
      wait_q      <= 4'h0;
      op_q        <= 8'h00;
      out_lo_q    <= 8'h00;
      opnd_q      <= 24'h000000;
      left_q      <= 2'h0;
      more_q      <= 1'b0;
      mem_valid_q <= 1'b0;
      ptr_q       <= 16'h0000;
      illegal_q   <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      mem_req_q   <= mem_req_d;
      cpu_seq_q   <= cpu_seq_d;
      div_q       <= div_d;
      tx_sh_q     <= tx_sh_d;
      tx_cnt_q    <= tx_cnt_d;
      rx_cnt_q    <= rx_cnt_d;
      rx_bit_q    <= rx_bit_d;
      rx_sh_q     <= rx_sh_d;
      rx_act_q    <= rx_act_d;
      rx_arm_q    <= rx_arm_d;
      sec_cnt_q   <= sec_cnt_d;
      sec_bad_q   <= sec_bad_d;
      sec_wr_q    <= sec_wr_d;
      wait_q      <= wait_d;
      op_q        <= op_d;
      out_lo_q    <= out_lo_d;
      opnd_q      <= opnd_d;
      left_q      <= left_d;
      more_q      <= more_d;
      mem_valid_q <= mem_valid_d;
      ptr_q       <= ptr_d;
      illegal_q   <= illegal_d;
    end
  end

  assign monitor_serial_pin_out  = tx_sh_q[0];
  assign monitor_serial_pin_oe_n = (tx_cnt_q == 4'h0);
  assign flash_unlocked          = unlock_q;
  assign illegal_addr_reset      = illegal_q;
  assign cpu_seq                 = cpu_seq_q;
  assign mem_valid               = mem_valid_q;
  assign mem_req                 = mem_req_q;

endmodule : monitor_debug_command_port

//--- sim/monitor_debug_command_port_assertions.sv
// Concurrent checks on the monitor command port top-level ports.
// Assumes sync resets on mclk; bit time follows int_osc_mode.
`timescale 1ns/1ps
module monitor_debug_command_port_assertions #(
  parameter int unsigned DIV_EXT = 256,
  parameter int unsigned DIV_INT = 335
) (
  // Clock, resets, mode
  input wire logic                  mclk,
  input wire logic                  reset,
  input wire logic                  por,
  input wire logic                  int_osc_mode,
  // Serial pin
  input wire logic                  monitor_serial_pin_out,
  input wire logic                  monitor_serial_pin_oe_n,
  // Security
  input wire logic                  flash_fetch,
  input wire logic                  flash_unlocked,
  input wire logic                  illegal_addr_reset,
  // CPU and memory
  input wire monitor_pkg::cpu_seq_t cpu_seq,
  input wire logic                  mem_valid,
  input wire monitor_pkg::mem_req_t mem_req,
  input wire logic                  mem_ready
);
  logic        oe_n;
  logic        out;
  logic [12:0] bt;
  logic [12:0] cnt_d;
  logic [12:0] cnt_q;
  logic [12:0] flen;
  logic [12:0] pos;

  assign oe_n = monitor_serial_pin_oe_n;
  assign out  = monitor_serial_pin_out;
  assign bt   = int_osc_mode ? 13'(DIV_INT) : 13'(DIV_EXT);
  assign flen = 13'hC * bt;
  // Position inside the current frame; stack query sends two frames back to back
  assign pos  = cnt_q % flen;

  // Cycles since the pin drive began
  always_comb cnt_d = oe_n ? 13'h0000 : cnt_q + 13'h0001;
  always_ff @(posedge mclk) cnt_q <= (reset || por) ? 13'h0000 : cnt_d;

  default clocking @(posedge mclk); endclocking
  default disable iff (reset || por);

  a_gap_high: assert property (!oe_n && pos < (bt << 1) |-> out)
    else $error("Lead-in of a frame not high");
  a_start_low: assert property (!oe_n && pos >= (bt << 1) && pos < 13'h3 * bt |-> !out)
    else $error("Start bit not low");
  a_frame_len: assert property ($rose(oe_n) |-> cnt_q != 13'h0000 && pos == 13'h0000)
    else $error("Frame drive not whole frames of twelve bit times");
  a_frame_max: assert property (!oe_n |-> cnt_q < (flen << 1))
    else $error("Frame drive too long");
  a_mem_hold: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_req))
    else $error("Memory request dropped or changed");
  a_mem_quiet: assert property (mem_valid |-> oe_n)
    else $error("Memory access while transmitting");
  a_illegal_set: assert property (flash_fetch && !flash_unlocked |=> illegal_addr_reset)
    else $error("Locked fetch gave no reset");
  a_illegal_cause: assert property (illegal_addr_reset |-> $past(flash_fetch) && !$past(flash_unlocked))
    else $error("Reset without locked fetch");
  a_unlock_keep: assert property (disable iff (por) !$fell(flash_unlocked))
    else $error("Unlock lost without power-on");
  a_trap_push: assert property (cpu_seq.software_trap_instr |=> cpu_seq.push_index_high_instr)
    else $error("Trap not followed by push");
  a_pop_return: assert property (cpu_seq.pop_index_high_instr |=> cpu_seq.return_from_trap_instr)
    else $error("Pop not followed by return");
endmodule : monitor_debug_command_port_assertions

bind monitor_debug_command_port monitor_debug_command_port_assertions #(
  .DIV_EXT(DIV_EXT),
  .DIV_INT(DIV_INT)
) u_chk (
  .mclk(mclk),
  .reset(reset),
  .por(por),
  .int_osc_mode(int_osc_mode),
  .monitor_serial_pin_out(monitor_serial_pin_out),
  .monitor_serial_pin_oe_n(monitor_serial_pin_oe_n),
  .flash_fetch(flash_fetch),
  .flash_unlocked(flash_unlocked),
  .illegal_addr_reset(illegal_addr_reset),
  .cpu_seq(cpu_seq),
  .mem_valid(mem_valid),
  .mem_req(mem_req),
  .mem_ready(mem_ready)
);

//--- sim/monitor_host_model.sv
// Host partner: sends frames open-drain on the pin and decodes what it sees.
// Assumes the bench resolves the pin as a wired-AND with a pullup.
`timescale 1ns/1ps
module monitor_host_model (
  // Clock and bit time
  input wire logic       mclk,
  input wire logic [8:0] bit_len,
  // Serial pin
  input wire logic       pin,
  output logic           drive_low_n
);
  logic [8:0] rx_q[$];
  logic       sending;
  logic [9:0] f;

  initial
  begin
    drive_low_n = 1'b1;
    sending     = 1'b0;
  end

  // One idle bit first so the device has left its stop bit
  task automatic send(input logic [7:0] b, input logic stp);
    logic [9:0] fr;
    fr = {stp, b, 1'b0};
    repeat (bit_len) @(posedge mclk);
    sending = 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      drive_low_n <= fr[i];
      repeat (bit_len) @(posedge mclk);
    end
    drive_low_n <= 1'b1;
    @(posedge mclk);
    sending = 1'b0;
  endtask : send

  // Mid-bit sampling of device frames, stop bit kept above the byte
  initial
  begin
    forever
    begin
      @(negedge pin);
      if (!sending)
      begin
        repeat (bit_len / 2) @(negedge mclk);
        for (int i = 0; i < 10; i++)
        begin
          f[i] = pin;
          if (i < 9)
            repeat (bit_len) @(negedge mclk);
        end
        rx_q.push_back({f[9], f[8:1]});
      end
    end
  end
endmodule : monitor_host_model

//--- sim/monitor_debug_command_port_tb.sv
// Bench: host model on the pin, memory model, one task per scenario.
// Assumes short baud divisors so that frames stay brief.
`timescale 1ns/1ps
module monitor_debug_command_port_tb;
  localparam int unsigned DE         = 8;
  localparam int unsigned DI         = 10;
  localparam logic [63:0] CODE       = 64'h8877665544332211;
  localparam logic [7:0]  RD_CMD     = 8'h4A;
  localparam logic [7:0]  WR_CMD     = 8'h49;
  localparam logic [7:0]  IFETCH_CMD = 8'h1A;
  localparam logic [7:0]  ISTORE_CMD = 8'h19;
  localparam logic [7:0]  SPQ_CMD    = 8'h0C;
  localparam logic [7:0]  RUN_CMD    = 8'h28;
  logic                  mclk, reset, por, int_osc_mode, pin, line_n, oe_n, pin_out;
  logic                  flash_fetch, flash_unlocked, illegal, mem_valid, mem_ready;
  logic [15:0]           stack_ptr;
  logic [7:0]            mem_rdata;
  logic [1:0]            dly_q;
  logic [8:0]            v;
  monitor_pkg::cpu_seq_t cpu_seq;
  monitor_pkg::mem_req_t mem_req, last_q;
  int                    n_errors, total_checks, n_mem;

  assign pin = line_n & (oe_n | pin_out);

  monitor_debug_command_port #(
    .DIV_EXT(DE), .DIV_INT(DI), .OP_READ(RD_CMD), .OP_WRITE(WR_CMD), .OP_IFETCH(IFETCH_CMD),
    .OP_ISTORE(ISTORE_CMD), .OP_SPQUERY(SPQ_CMD), .OP_RUN(RUN_CMD)
  ) u_dut (
    .mclk(mclk), .reset(reset), .por(por), .int_osc_mode(int_osc_mode),
    .monitor_serial_pin_in(pin), .monitor_serial_pin_out(pin_out),
    .monitor_serial_pin_oe_n(oe_n), .flash_code(CODE), .flash_fetch(flash_fetch),
    .flash_unlocked(flash_unlocked), .illegal_addr_reset(illegal), .stack_ptr(stack_ptr),
    .cpu_seq(cpu_seq), .mem_valid(mem_valid), .mem_req(mem_req), .mem_ready(mem_ready),
    .mem_rdata(mem_rdata)
  );

  monitor_host_model u_host (
    .mclk(mclk), .bit_len(int_osc_mode ? 9'h00A : 9'h008), .pin(pin), .drive_low_n(line_n)
  );

  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[15:8] ^ a[7:0] ^ 8'h3C;
  endfunction : pat

  // Memory answers every request three cycles late
  always @(posedge mclk)
  begin
    dly_q     <= (mem_valid && !mem_ready) ? dly_q + 2'h1 : 2'h0;
    mem_ready <= mem_valid && !mem_ready && dly_q == 2'h2;
    mem_rdata <= pat(mem_req.addr);
    if (mem_valid && mem_ready)
    begin
      last_q <= mem_req;
      n_mem  <= n_mem + 1;
    end
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic get_rx();
    int n;
    n = 0;
    while (u_host.rx_q.size() == 0 && n < 3000)
    begin
      @(posedge mclk);
      n++;
    end
    v = (n < 3000) ? u_host.rx_q.pop_front() : 9'h1FF;
  endtask : get_rx

  task automatic tx(input logic [7:0] b);
    u_host.send(b, 1'b1);
    get_rx();
    check("echo", {7'h00, 1'b1, b}, {7'h00, v});
  endtask : tx

  task automatic rx_data(input logic [7:0] b);
    get_rx();
    check("data", {7'h00, 1'b1, b}, {7'h00, v});
  endtask : rx_data

  task automatic rx_brk();
    get_rx();
    check("break", 16'h0000, {7'h00, v});
  endtask : rx_brk

  task automatic wait_mem(input int n0);
    for (int n = 0; n < 3000 && n_mem == n0; n++)
      @(posedge mclk);
    check("mem count", 16'(n0 + 1), 16'(n_mem));
  endtask : wait_mem

  task automatic do_reset(input logic p);
    reset <= 1'b1;
    por   <= p;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    por   <= 1'b0;
    u_host.rx_q.delete();
    repeat (3) @(posedge mclk);
  endtask : do_reset

  task automatic t_sec(input logic [63:0] code);
    logic m;
    int   n0;
    m  = (code === CODE);
    n0 = n_mem;
    do_reset(1'b1);
    for (int k = 0; k < 8; k++)
      tx(code[8*k +: 8]);
    wait_mem(n0);
    check("flag addr", 16'h0080, last_q.addr);
    check("flag data", {7'h00, 1'b1, m ? 8'h40 : 8'h00}, {7'h00, last_q.we, last_q.wdata});
    rx_brk();
    check("unlocked", {15'h0000, m}, {15'h0000, flash_unlocked});
    flash_fetch <= 1'b1;
    repeat (2) @(posedge mclk);
    flash_fetch <= 1'b0;
    @(negedge mclk);
    check("illegal", {15'h0000, !m}, {15'h0000, illegal});
    @(posedge mclk);
  endtask : t_sec

  task automatic t_addr(input logic [7:0] op, input logic [15:0] a);
    tx(op);
    tx(a[15:8]);
    tx(a[7:0]);
  endtask : t_addr

  task automatic t_read(input logic [15:0] a);
    t_addr(RD_CMD, a);
    rx_data(pat(a));
    check("read addr", a, last_q.addr);
  endtask : t_read

  task automatic t_write(input logic [15:0] a, input logic [7:0] d);
    int n0;
    n0 = n_mem;
    t_addr(WR_CMD, a);
    tx(d);
    wait_mem(n0);
    check("write addr", a, last_q.addr);
    check("write data", {7'h00, 1'b1, d}, {7'h00, last_q.we, last_q.wdata});
  endtask : t_write

  task automatic t_ifetch(input logic [15:0] a);
    tx(IFETCH_CMD);
    rx_data(pat(a));
    check("ifetch addr", a, last_q.addr);
  endtask : t_ifetch

  task automatic t_istore(input logic [15:0] a, input logic [7:0] d);
    int n0;
    n0 = n_mem;
    tx(ISTORE_CMD);
    tx(d);
    wait_mem(n0);
    check("istore addr", a, last_q.addr);
    check("istore data", {7'h00, 1'b1, d}, {7'h00, last_q.we, last_q.wdata});
  endtask : t_istore

  task automatic t_spq(input logic [15:0] sp);
    logic [15:0] e;
    e         = sp + 16'h0001;
    stack_ptr <= sp;
    tx(SPQ_CMD);
    rx_data(e[15:8]);
    rx_data(e[7:0]);
  endtask : t_spq

  task automatic t_abort();
    int n0;
    n0 = n_mem;
    t_addr(WR_CMD, 16'h0100);
    tx(8'h55);
    u_host.send(8'h00, 1'b0);
    rx_brk();
    check("aborted write", 16'(n0), 16'(n_mem));
  endtask : t_abort

  task automatic t_run(input logic [15:0] sp);
    int n;
    t_write(sp + 16'h0005, 8'h80);
    tx(RUN_CMD);
    for (n = 0; n < 3000 && cpu_seq.pop_index_high_instr !== 1'b1; n++)
      @(negedge mclk);
    check("pop", 16'h0001, {15'h0000, cpu_seq.pop_index_high_instr});
    @(negedge mclk);
    check("return", 16'h0001, {15'h0000, cpu_seq.return_from_trap_instr});
  endtask : t_run

  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial
  begin
    repeat (60000) @(posedge mclk);
    n_errors++;
    end_of_test();
  end

  initial
  begin
    reset        = 1'b1;
    por          = 1'b1;
    int_osc_mode = 1'b0;
    flash_fetch  = 1'b0;
    stack_ptr    = 16'h0000;
    mem_ready    = 1'b0;
    mem_rdata    = 8'h00;
    dly_q        = 2'h0;
    n_mem        = 0;
    t_sec(CODE ^ 64'h0000000000000001);
    t_sec(CODE);
    t_read(16'h1234);
    t_ifetch(16'h1235);
    t_istore(16'h1236, 8'hA5);
    t_write(16'hFFFF, 8'h3C);
    t_ifetch(16'h0000);
    t_spq(16'h00FF);
    t_abort();
    int_osc_mode <= 1'b1;
    do_reset(1'b0);
    rx_brk();
    check("kept unlock", 16'h0001, {15'h0000, flash_unlocked});
    t_spq(16'h7FFE);
    t_run(16'h00F0);
    end_of_test();
  end
endmodule : monitor_debug_command_port_tb
